// file: design/fcs_pkg.sv
// constants, types and helpers shared by the four-channel output sequencer
package fcs_pkg;

    // converter geometry
    localparam int CHANNELS = 4;
    localparam int RESULT_BITS = 22;
    localparam int WORD_BITS = 32;

    // modulator clock divisor and last count of its divider
    localparam int MOD_DIV = 14;
    localparam logic [3:0] MOD_LAST = 4'(MOD_DIV - 1);

    // modulator samples per output update at cutoff index zero
    localparam int DECIM_BASE = 256;
    localparam logic [2:0] CUTOFF_MAX = 3'h4;

    // master-mode serial clock: system cycles per half period
    localparam int SCLK_HALF = 4;
    localparam logic [2:0] SCLK_HALF_LAST = 3'(SCLK_HALF - 1);

    // output word layout
    localparam int WORD_DATA_LSB = 10;
    localparam int WORD_CHAN_LSB = 8;
    localparam int WORD_ADDR_LSB = 5;
    localparam int WORD_AUX_BIT = 4;
    localparam logic [4:0] WORD_LAST_BIT = 5'h1F;

    // control word layout and reset value
    localparam int CTRL_BITS = 8;
    localparam logic [3:0] CTRL_COUNT_FULL = 4'h8;
    localparam int CTRL_CUTOFF_LSB = 5;
    localparam int CTRL_OUT_A_BIT = 4;
    localparam int CTRL_OUT_B_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // positions in the synchronised pin vector
    localparam int PIN_W = 10;
    localparam int PIN_SCLK = 0;
    localparam int PIN_RFS = 1;
    localparam int PIN_SDATA = 2;
    localparam int PIN_TFS = 3;
    localparam int PIN_AUX = 4;
    localparam int PIN_CHAIN = 5;
    localparam int PIN_MODE = 6;
    localparam int PIN_ADDR_LSB = 7;
    // frame syncs idle high, everything else low
    localparam logic [9:0] PIN_RESET = 10'h00A;

    typedef enum logic [2:0] {
        FCS_IDLE,
        FCS_FILL,
        FCS_LOAD,
        FCS_READY,
        FCS_SEND
    } fcs_state_t;

    // clamp the cutoff select to the five legal settings
    function automatic logic [2:0] fcs_cutoff_n(input logic [2:0] sel);
        return (sel > CUTOFF_MAX) ? CUTOFF_MAX : sel;
    endfunction : fcs_cutoff_n

    // build one output word from a channel result and its tags
    function automatic logic [31:0] fcs_pack_word(
        input logic [21:0] result,
        input logic [1:0] chan,
        input logic [2:0] addr,
        input logic aux
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[WORD_DATA_LSB +: RESULT_BITS] = result;
        w[WORD_CHAN_LSB +: 2] = chan;
        w[WORD_ADDR_LSB +: 3] = addr;
        w[WORD_AUX_BIT] = aux;
        return w;
    endfunction : fcs_pack_word

endpackage : fcs_pkg

// file: design/fcs_word_store.sv
// four-word store for the output words, registered read
`timescale 1ns/10ps
module fcs_word_store (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [1:0] wr_addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic [1:0] rd_addr_in,
    output logic [31:0] rd_data_out
);

    logic [31:0] mem [4];

    always_ff @(posedge sys_clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 32'h0000_0000;
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end

endmodule : fcs_word_store

// file: design/fcs_sequencer.sv
// output sequencer, control register and rate generation of the converter
`timescale 1ns/10ps
module fcs_sequencer #(
    parameter int DECIM_BASE = fcs_pkg::DECIM_BASE
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic serial_clk_in,
    output logic serial_clk_out,
    output logic serial_clk_oe_out,
    input wire logic receive_frame_sync_n_in,
    output logic receive_frame_sync_n_out,
    output logic receive_frame_sync_oe_out,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    input wire logic control_write_frame_n_in,
    input wire logic aux_flag_input_in,
    input wire logic chain_enable_in,
    input wire logic mode_slave_in,
    input wire logic [2:0] dev_addr_in,
    input wire logic [21:0] chan_result_in [4],
    output logic word_available_n_out,
    output logic chain_done_out,
    output logic mod_sample_out,
    output logic filter_reload_out,
    output logic cutoff_select_bit2_out,
    output logic cutoff_select_bit1_out,
    output logic cutoff_select_bit0_out,
    output logic front_end_ctrl_out_a_out,
    output logic front_end_ctrl_out_b_out
);

    // pin synchronisers
    logic [9:0] pin_raw;
    logic [9:0] pin_s1;
    logic [9:0] pin_s2;
    logic [9:0] pin_s3;
    logic [9:0] pin_f;
    logic [9:0] pin_q;
    logic [9:0] pin_agree;

    assign pin_raw = {dev_addr_in, mode_slave_in, chain_enable_in, aux_flag_input_in,
                      control_write_frame_n_in, serial_data_in, receive_frame_sync_n_in,
                      serial_clk_in};
    assign pin_agree = ~(pin_s2 ^ pin_s3);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s1 <= fcs_pkg::PIN_RESET;
            pin_s2 <= fcs_pkg::PIN_RESET;
            pin_s3 <= fcs_pkg::PIN_RESET;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // a pin change counts once the second and third stages agree
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_f <= fcs_pkg::PIN_RESET;
            pin_q <= fcs_pkg::PIN_RESET;
        end else begin
            pin_f <= (pin_s3 & pin_agree) | (pin_f & ~pin_agree);
            pin_q <= pin_f;
        end
    end

    logic slave_mode;
    logic chain_en;
    logic aux_level;
    logic rfs_n_pin;
    logic sdata_pin;
    logic tfs_framed;
    logic tfs_end;
    logic [2:0] dev_addr;

    assign slave_mode = pin_f[fcs_pkg::PIN_MODE];
    assign chain_en = pin_f[fcs_pkg::PIN_CHAIN];
    assign aux_level = pin_f[fcs_pkg::PIN_AUX];
    assign rfs_n_pin = pin_f[fcs_pkg::PIN_RFS];
    assign sdata_pin = pin_f[fcs_pkg::PIN_SDATA];
    assign tfs_framed = ~pin_f[fcs_pkg::PIN_TFS];
    assign tfs_end = pin_f[fcs_pkg::PIN_TFS] & ~pin_q[fcs_pkg::PIN_TFS];
    assign dev_addr = pin_f[fcs_pkg::PIN_ADDR_LSB +: 3];

    // master serial clock divider, free running in master mode
    logic [2:0] sclk_div;
    logic sclk_int;
    logic sclk_toggle;
    logic sclk_fall;

    assign sclk_toggle = (sclk_div == fcs_pkg::SCLK_HALF_LAST);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_div <= 3'h0;
            sclk_int <= 1'b0;
        end else if (sclk_toggle) begin
            sclk_div <= 3'h0;
            sclk_int <= ~sclk_int;
        end else begin
            sclk_div <= sclk_div + 3'h1;
        end
    end

    // falling serial clock edge from our own divider or from the host
    always_comb begin
        if (slave_mode) begin
            sclk_fall = ~pin_f[fcs_pkg::PIN_SCLK] & pin_q[fcs_pkg::PIN_SCLK];
        end else begin
            sclk_fall = sclk_toggle & sclk_int;
        end
    end

    // control register write
    logic [3:0] ctrl_cnt;
    logic [7:0] ctrl_shift;
    logic [7:0] ctrl_reg;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_cnt <= 4'h0;
            ctrl_shift <= fcs_pkg::CTRL_RESET;
        end else if (!tfs_framed) begin
            ctrl_cnt <= 4'h0;
        end else if (sclk_fall && ctrl_cnt != fcs_pkg::CTRL_COUNT_FULL) begin
            ctrl_shift <= {ctrl_shift[6:0], sdata_pin};
            ctrl_cnt <= ctrl_cnt + 4'h1;
        end
    end

    // a complete word is committed when the frame closes
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg <= fcs_pkg::CTRL_RESET;
        end else if (tfs_end && ctrl_cnt == fcs_pkg::CTRL_COUNT_FULL) begin
            ctrl_reg <= ctrl_shift;
        end
    end

    assign front_end_ctrl_out_a_out = ctrl_reg[fcs_pkg::CTRL_OUT_A_BIT];
    assign front_end_ctrl_out_b_out = ctrl_reg[fcs_pkg::CTRL_OUT_B_BIT];

    logic [2:0] cutoff_sel;
    logic [2:0] cutoff_n;

    assign cutoff_sel = ctrl_reg[fcs_pkg::CTRL_CUTOFF_LSB +: 3];
    assign cutoff_n = fcs_pkg::fcs_cutoff_n(cutoff_sel);
    assign cutoff_select_bit2_out = cutoff_sel[2];
    assign cutoff_select_bit1_out = cutoff_sel[1];
    assign cutoff_select_bit0_out = cutoff_sel[0];

    // modulator sample divider
    logic [3:0] mod_cnt;
    logic mod_tick;

    assign mod_tick = (mod_cnt == fcs_pkg::MOD_LAST);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mod_cnt <= 4'h0;
        end else if (mod_tick) begin
            mod_cnt <= 4'h0;
        end else begin
            mod_cnt <= mod_cnt + 4'h1;
        end
    end

    // output update divider in modulator samples
    logic [15:0] dec_cnt;
    logic [15:0] dec_limit;
    logic update_tick;

    assign dec_limit = 16'((DECIM_BASE << cutoff_n) - 1);
    assign update_tick = mod_tick && (dec_cnt >= dec_limit);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dec_cnt <= 16'h0000;
        end else if (update_tick) begin
            dec_cnt <= 16'h0000;
        end else if (mod_tick) begin
            dec_cnt <= dec_cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mod_sample_out <= 1'b0;
            filter_reload_out <= 1'b0;
        end else begin
            mod_sample_out <= mod_tick;
            filter_reload_out <= update_tick;
        end
    end

    // output word store
    fcs_pkg::fcs_state_t state;
    logic [1:0] word_idx;
    logic [4:0] bit_cnt;
    logic [31:0] shift;
    logic [31:0] store_rd;
    logic [31:0] store_wd;
    logic store_we;
    logic frame_n;
    logic send_start;

    assign store_we = (state == fcs_pkg::FCS_FILL);
    assign store_wd = fcs_pkg::fcs_pack_word(chan_result_in[word_idx], word_idx,
                                             dev_addr, aux_level);

    fcs_word_store u_store (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .wr_en_in(store_we),
        .wr_addr_in(word_idx),
        .wr_data_in(store_wd),
        .rd_addr_in(word_idx),
        .rd_data_out(store_rd)
    );

    // a word leaves when the chain enables us and a frame opens
    always_comb begin
        if (slave_mode) begin
            send_start = chain_en & ~rfs_n_pin;
        end else begin
            send_start = chain_en & sclk_toggle & sclk_int;
        end
    end

    // transfer sequence; a new update restarts it
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= fcs_pkg::FCS_IDLE;
            word_idx <= 2'h0;
            bit_cnt <= 5'h00;
        end else if (update_tick) begin
            state <= fcs_pkg::FCS_FILL;
            word_idx <= 2'h0;
        end else begin
            unique case (state)
                fcs_pkg::FCS_IDLE: begin
                    word_idx <= 2'h0;
                end
                fcs_pkg::FCS_FILL: begin
                    word_idx <= word_idx + 2'h1;
                    if (word_idx == 2'h3) begin
                        state <= fcs_pkg::FCS_LOAD;
                    end
                end
                fcs_pkg::FCS_LOAD: begin
                    state <= fcs_pkg::FCS_READY;
                end
                fcs_pkg::FCS_READY: begin
                    if (send_start) begin
                        state <= fcs_pkg::FCS_SEND;
                        bit_cnt <= 5'h00;
                    end
                end
                fcs_pkg::FCS_SEND: begin
                    if (slave_mode && rfs_n_pin) begin
                        state <= fcs_pkg::FCS_READY;
                    end else if (sclk_fall) begin
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == fcs_pkg::WORD_LAST_BIT) begin
                            if (word_idx == 2'h3) begin
                                state <= fcs_pkg::FCS_IDLE;
                            end else begin
                                state <= fcs_pkg::FCS_LOAD;
                                word_idx <= word_idx + 2'h1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // shift register and serial data line
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift <= 32'h0000_0000;
        end else if (state == fcs_pkg::FCS_READY && send_start) begin
            shift <= store_rd;
        end else if (state == fcs_pkg::FCS_SEND && sclk_fall) begin
            shift <= {shift[30:0], 1'b0};
        end
    end

    assign serial_data_out = shift[31];
    assign serial_data_oe_out = (state == fcs_pkg::FCS_SEND);

    // master frame sync around each word
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_n <= 1'b1;
        end else if (state == fcs_pkg::FCS_READY && send_start) begin
            frame_n <= 1'b0;
        end else if (state != fcs_pkg::FCS_SEND) begin
            frame_n <= 1'b1;
        end else if (sclk_fall && bit_cnt == fcs_pkg::WORD_LAST_BIT) begin
            frame_n <= 1'b1;
        end
    end

    assign receive_frame_sync_n_out = frame_n;
    assign receive_frame_sync_oe_out = ~slave_mode;
    assign serial_clk_out = sclk_int;
    assign serial_clk_oe_out = ~slave_mode;

    // chain done after the last word, cleared by the next update
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            chain_done_out <= 1'b0;
        end else if (state == fcs_pkg::FCS_SEND && sclk_fall
                     && bit_cnt == fcs_pkg::WORD_LAST_BIT && word_idx == 2'h3) begin
            chain_done_out <= 1'b1;
        end else if (update_tick) begin
            chain_done_out <= 1'b0;
        end
    end

    // low while a loaded word waits or shifts; high when idle, filling or loading
    assign word_available_n_out = ~(state == fcs_pkg::FCS_READY
                                    || state == fcs_pkg::FCS_SEND);

endmodule : fcs_sequencer

// file: test/fcs_sequencer_props.sv
// concurrent assertions on the output sequencer ports
`timescale 1ns/10ps
module fcs_sequencer_props (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic control_write_frame_n_in,
    input wire logic mode_slave_in,
    input wire logic serial_clk_out,
    input wire logic serial_clk_oe_out,
    input wire logic receive_frame_sync_n_out,
    input wire logic receive_frame_sync_oe_out,
    input wire logic serial_data_oe_out,
    input wire logic word_available_n_out,
    input wire logic chain_done_out,
    input wire logic mod_sample_out,
    input wire logic filter_reload_out,
    input wire logic cutoff_select_bit2_out,
    input wire logic cutoff_select_bit1_out,
    input wire logic cutoff_select_bit0_out,
    input wire logic front_end_ctrl_out_a_out,
    input wire logic front_end_ctrl_out_b_out
);
    logic sclk_q;
    logic [5:0] fall_cnt;
    logic [4:0] ctrl_outs;
    assign ctrl_outs = {cutoff_select_bit2_out, cutoff_select_bit1_out, cutoff_select_bit0_out,
                        front_end_ctrl_out_a_out, front_end_ctrl_out_b_out};
    // serial clock falls seen while a word is on the wire
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_q <= 1'b0;
            fall_cnt <= 6'h00;
        end else begin
            sclk_q <= serial_clk_out;
            if (!serial_data_oe_out) begin
                fall_cnt <= 6'h00;
            end else if (sclk_q && !serial_clk_out) begin
                fall_cnt <= fall_cnt + 6'h01;
            end
        end
    end
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    sequence load_ready;
        word_available_n_out ##1 !word_available_n_out;
    endsequence
    chk_mod_period: assert property (mod_sample_out |-> ##14 mod_sample_out)
        else $error("modulator strobe period wrong");
    chk_mod_gap: assert property (mod_sample_out |=> !mod_sample_out [*8])
        else $error("modulator strobe too soon");
    chk_reload_load: assert property (filter_reload_out |-> ##4 load_ready)
        else $error("word load after reload wrong");
    chk_word_gap: assert property ($rose(word_available_n_out) && !chain_done_out
        && !filter_reload_out |-> load_ready)
        else $error("gap between words wrong");
    chk_reload_gap: assert property (filter_reload_out |=> !filter_reload_out [*8])
        else $error("output updates too close");
    chk_done_end: assert property ($rose(chain_done_out) |->
        word_available_n_out && $past(serial_data_oe_out))
        else $error("chain done without finished transfer");
    chk_send_start: assert property ($rose(serial_data_oe_out) && !mode_slave_in |->
        !receive_frame_sync_n_out && !word_available_n_out)
        else $error("word started without frame");
    chk_word_bits: assert property ($fell(serial_data_oe_out) && !filter_reload_out
        && !mode_slave_in |->
        fall_cnt inside {[6'h1F:6'h21]})
        else $error("word length wrong");
    chk_ctrl_framed: assert property ($changed(ctrl_outs) |->
        control_write_frame_n_in && $past(control_write_frame_n_in, 2))
        else $error("control outputs changed inside frame");
    chk_oe_mode: assert property (!mode_slave_in [*6] |->
        serial_clk_oe_out && receive_frame_sync_oe_out)
        else $error("master mode enables missing");
endmodule : fcs_sequencer_props
bind fcs_sequencer fcs_sequencer_props u_props (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .control_write_frame_n_in(control_write_frame_n_in),
    .mode_slave_in(mode_slave_in),
    .serial_clk_out(serial_clk_out),
    .serial_clk_oe_out(serial_clk_oe_out),
    .receive_frame_sync_n_out(receive_frame_sync_n_out),
    .receive_frame_sync_oe_out(receive_frame_sync_oe_out),
    .serial_data_oe_out(serial_data_oe_out),
    .word_available_n_out(word_available_n_out),
    .chain_done_out(chain_done_out),
    .mod_sample_out(mod_sample_out),
    .filter_reload_out(filter_reload_out),
    .cutoff_select_bit2_out(cutoff_select_bit2_out),
    .cutoff_select_bit1_out(cutoff_select_bit1_out),
    .cutoff_select_bit0_out(cutoff_select_bit0_out),
    .front_end_ctrl_out_a_out(front_end_ctrl_out_a_out),
    .front_end_ctrl_out_b_out(front_end_ctrl_out_b_out)
);

// file: test/fcs_host_model.sv
// host serial port model: collects output words, writes control words
`timescale 1ns/10ps
module fcs_host_model (
    input wire logic sys_clk_in,
    input wire logic serial_clk_in,
    input wire logic frame_n_in,
    input wire logic data_in,
    output logic ctrl_frame_n_out,
    output logic ctrl_data_out
);
    logic [31:0] rx_q [$];
    logic [31:0] shift = 32'h0000_0000;
    logic [5:0] cnt = 6'h00;
    logic sclk_q = 1'b0;
    logic writing = 1'b0;
    initial begin
        ctrl_frame_n_out = 1'b1;
        ctrl_data_out = 1'b0;
    end
    // bits taken mid-bit on rising clock, only inside the frame
    always @(posedge sys_clk_in) begin
        sclk_q <= serial_clk_in;
        if (frame_n_in) begin
            cnt <= 6'h00;
        end else if (serial_clk_in && !sclk_q) begin
            shift <= {shift[30:0], data_in};
            cnt <= cnt + 6'h01;
        end
        if (cnt == 6'h20) begin
            rx_q.push_back(shift);
            cnt <= 6'h00;
        end
    end
    // unframed data line keeps changing
    always @(negedge sys_clk_in) begin
        if (!writing) begin
            ctrl_data_out <= ~ctrl_data_out;
        end
    end
    task automatic wait_fall;
        int i;
        for (i = 0; i < 40; i++) begin
            @(negedge sys_clk_in);
            if (!serial_clk_in && sclk_q) begin
                return;
            end
        end
        tb.check("host clock", 32'h0, 32'h1);
        tb.report_and_stop();
    endtask : wait_fall
    // framed write, msb first, data changed just after each falling clock
    task automatic write_ctrl(input logic [7:0] v, input int n);
        int k;
        writing = 1'b1;
        wait_fall();
        ctrl_frame_n_out = 1'b0;
        for (k = 7; k > 7 - n; k--) begin
            ctrl_data_out = v[k];
            wait_fall();
        end
        ctrl_frame_n_out = 1'b1;
        @(negedge sys_clk_in);
        writing = 1'b0;
    endtask : write_ctrl
endmodule : fcs_host_model

// file: test/tb.sv
// self-checking testbench for the output sequencer
`timescale 1ns/10ps
module tb;
    localparam int DB = 16;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic chain_enable_in = 1'b1;
    logic aux_flag_input_in = 1'b0;
    logic [2:0] dev_addr_in = 3'h0;
    logic mode_slave = 1'b0;
    logic host_sclk = 1'b0;
    logic host_rfs_n = 1'b1;
    logic [21:0] chan_result_in [4] = '{22'h3FFFFF, 22'h000001, 22'h2AAAAA, 22'h155555};
    logic control_write_frame_n_in, serial_data_in;
    logic serial_clk_out, serial_clk_oe_out, rfs_n, rfs_oe, serial_data_out, serial_data_oe_out;
    logic word_available_n_out, chain_done_out, mod_sample_out, filter_reload_out;
    logic cut2, cut1, cut0, fea, feb;
    int mismatches = 0;
    int num_checks = 0;
    fcs_sequencer #(.DECIM_BASE(DB)) u_dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .serial_clk_in(host_sclk), .serial_clk_out(serial_clk_out),
        .serial_clk_oe_out(serial_clk_oe_out), .receive_frame_sync_n_in(host_rfs_n),
        .receive_frame_sync_n_out(rfs_n), .receive_frame_sync_oe_out(rfs_oe),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_oe_out(serial_data_oe_out),
        .control_write_frame_n_in(control_write_frame_n_in),
        .aux_flag_input_in(aux_flag_input_in), .chain_enable_in(chain_enable_in),
        .mode_slave_in(mode_slave), .dev_addr_in(dev_addr_in), .chan_result_in(chan_result_in),
        .word_available_n_out(word_available_n_out), .chain_done_out(chain_done_out),
        .mod_sample_out(mod_sample_out), .filter_reload_out(filter_reload_out),
        .cutoff_select_bit2_out(cut2), .cutoff_select_bit1_out(cut1),
        .cutoff_select_bit0_out(cut0), .front_end_ctrl_out_a_out(fea),
        .front_end_ctrl_out_b_out(feb)
    );
    fcs_host_model u_host (
        .sys_clk_in(sys_clk_in), .serial_clk_in(mode_slave ? host_sclk : serial_clk_out),
        .frame_n_in(mode_slave ? host_rfs_n : rfs_n),
        .data_in(serial_data_out), .ctrl_frame_n_out(control_write_frame_n_in),
        .ctrl_data_out(serial_data_in)
    );
    initial begin
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic wait_sig(input logic done_sel, input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge sys_clk_in);
            if ((done_sel ? chain_done_out : filter_reload_out) === v) begin
                return;
            end
        end
        check("wait", 32'h0, 32'h1);
        report_and_stop();
    endtask : wait_sig
    task automatic t_reset;
        int i;
        rst_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        check("reset outs", 32'({word_available_n_out, chain_done_out, serial_data_oe_out,
            cut2, cut1, cut0, fea, feb}), 32'h80);
        rst_in = 1'b0;
        i = 0;
        do begin
            @(negedge sys_clk_in);
            i++;
        end while (mod_sample_out !== 1'b1 && i < 30);
        check("first strobe", 32'(i), 32'(fcs_pkg::MOD_DIV));
    endtask : t_reset
    task automatic t_ctrl;
        u_host.write_ctrl(8'h98, 8);
        repeat (12) @(negedge sys_clk_in);
        check("ctrl", 32'({cut2, cut1, cut0, fea, feb}), 32'h13);
        u_host.write_ctrl(8'h08, 5);
        repeat (12) @(negedge sys_clk_in);
        check("short frame", 32'({cut2, cut1, cut0, fea, feb}), 32'h13);
        u_host.write_ctrl(8'h68, 8);
        repeat (12) @(negedge sys_clk_in);
        check("ctrl", 32'({cut2, cut1, cut0, fea, feb}), 32'h0D);
    endtask : t_ctrl
    task automatic t_rate;
        int s, n, cnt;
        for (s = 0; s < 6; s++) begin
            n = (s == 5) ? 4 : s;
            u_host.write_ctrl(8'(((s == 5) ? 7 : s) << 5), 8);
            wait_sig(1'b0, 1'b1, 8000);
            wait_sig(1'b0, 1'b1, 8000);
            cnt = 0;
            do begin
                @(negedge sys_clk_in);
                cnt++;
            end while (filter_reload_out !== 1'b1 && cnt < 4000);
            check("period", 32'(cnt), 32'((14 * DB) << n));
        end
    endtask : t_rate
    task automatic t_words(input logic aux, input logic [2:0] addr);
        int c;
        aux_flag_input_in = aux;
        dev_addr_in = addr;
        u_host.write_ctrl(8'h60, 8);
        wait_sig(1'b0, 1'b1, 8000);
        wait_sig(1'b0, 1'b1, 8000);
        u_host.rx_q.delete();
        wait_sig(1'b1, 1'b0, 20);
        wait_sig(1'b1, 1'b1, 1700);
        check("avail", 32'(word_available_n_out), 32'h1);
        check("count", 32'(u_host.rx_q.size()), 32'h4);
        for (c = 0; c < 4 && c < u_host.rx_q.size(); c++) begin
            check("word", u_host.rx_q[c], {chan_result_in[c], 2'(c), addr, aux, 4'h0});
        end
    endtask : t_words
    task automatic t_block;
        chain_enable_in = 1'b0;
        wait_sig(1'b0, 1'b1, 4000);
        u_host.rx_q.delete();
        repeat (300) @(negedge sys_clk_in);
        check("avail", 32'(word_available_n_out), 32'h0);
        check("oe", 32'(serial_data_oe_out), 32'h0);
        chain_enable_in = 1'b1;
        wait_sig(1'b1, 1'b1, 1700);
        check("count", 32'(u_host.rx_q.size()), 32'h4);
    endtask : t_block
    task automatic t_slave;
        int b;
        mode_slave = 1'b1;
        wait_sig(1'b0, 1'b1, 4000);
        u_host.rx_q.delete();
        repeat (8) @(negedge sys_clk_in);
        check("slave oe", 32'({serial_clk_oe_out, rfs_oe}), 32'h0);
        host_rfs_n = 1'b0;
        for (b = 0; b < 32; b++) begin
            repeat (12) @(negedge sys_clk_in);
            host_sclk = 1'b1;
            repeat (12) @(negedge sys_clk_in);
            host_sclk = 1'b0;
        end
        @(negedge sys_clk_in);
        host_rfs_n = 1'b1;
        repeat (12) @(negedge sys_clk_in);
        check("slave count", 32'(u_host.rx_q.size()), 32'h1);
        check("slave word", (u_host.rx_q.size() > 0) ? u_host.rx_q[0] : 32'h0,
            {chan_result_in[0], 2'h0, dev_addr_in, aux_flag_input_in, 4'h0});
        check("slave avail", 32'(word_available_n_out), 32'h0);
    endtask : t_slave
    initial begin
        repeat (12) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rst_in = 1'b0;
        repeat (8) @(negedge sys_clk_in);
        t_reset();
        t_ctrl();
        t_rate();
        t_words(1'b1, 3'h5);
        t_words(1'b0, 3'h2);
        t_block();
        t_slave();
        report_and_stop();
    end
endmodule : tb
